/* design/spf_params.svh */
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: 32-bit avalon data, byte addresses
// Notes: included by the pin-function block and the bench top
`ifndef SPF_PARAMS_SVH
`define SPF_PARAMS_SVH
// =====================================================================
// register map (byte addresses)
`define SPF_CTRL_ADDR 4'h0
`define SPF_CMD_ADDR 4'h4
`define SPF_STATUS_ADDR 4'h8
// control register fields
`define SPF_CTRL_MODE_LSB 0
`define SPF_CTRL_FMT_BIT 2
`define SPF_CTRL_PDOWN_BIT 3
// command codes
`define SPF_PIN_DEFINE_COMMAND_TOP 5'h1C
`define SPF_D_CLOCK_ENABLE_COMMAND_CODE 8'hF1
// reset values
`define SPF_RST_FMT 1'h0
`define SPF_RST_PDOWN 1'h1
// =====================================================================
// timing: system clock and recovered clock rates
`define SPF_CLK_HZ 200000000
`define SPF_RCLK_F0_HZ 512000
`define SPF_RCLK_F1_HZ 2048000
`define SPF_HALF_F0 (`SPF_CLK_HZ / (2 * `SPF_RCLK_F0_HZ))
`define SPF_HALF_F1 (`SPF_CLK_HZ / (2 * `SPF_RCLK_F1_HZ))
`define SPF_FRAME_HZ 8000
`define SPF_FRAME_F0 (`SPF_RCLK_F0_HZ / `SPF_FRAME_HZ)
`define SPF_FRAME_F1 (`SPF_RCLK_F1_HZ / `SPF_FRAME_HZ)
// slot layout: b1 bits 0..7, b2 bits 8..15, d bits 16..17
`define SPF_B2_FIRST 8'h08
`define SPF_B2_LAST 8'h0F
`define SPF_D_FIRST 8'h10
`define SPF_LAST_BIT 8'h11
`endif

/* design/spf_pkg.sv */
// Purpose: types for the system interface pin-function block
// Assumes: spf_params.svh holds the numbers
// Notes: state is one packed struct
package spf_pkg;
  // =====================================================================
  // device modes and pin functions
  typedef enum logic [1:0] {SPF_NTA, SPF_NTF, SPF_TEM, SPF_TES} spf_mode_t;
  typedef enum logic [1:0] {SPF_P1_WAKE, SPF_P1_RXWIN, SPF_P1_RCLK, SPF_P1_TXWIN} spf_p1_t;
  // avalon request bundle
  typedef struct packed {
    logic [3:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
  } spf_av_req_t;
  // =====================================================================
  // complete block state
  typedef struct packed {
    logic bclk_s1, bclk_s2, fs_s1, fs_s2, txd_s1, txd_s2, lsd_s1, lsd_s2, lock_s1, lock_s2;
    logic bk_d, fs_d, lock_d, pend;
    logic [7:0] div_cnt;
    logic rclk;
    logic [7:0] fcnt, bit_cnt;
    logic active;
    logic [17:0] rx_sh, tx_sh, tx_data;
    logic tx_valid;
    spf_mode_t mode;
    logic fmt, pdown, d_clock_enable_command;
    spf_p1_t p1_sel;
    logic p2_sel;
    logic rd_out, rd_oe, fs_out, fs_oe, p1_out, p1_oe, p2_out;
    logic wait_q;
    logic [31:0] rdata;
  } spf_state_t;
endpackage : spf_pkg

/* design/spf_pin_function.sv */
// Purpose: strobe, serial data and alternate pin functions of the system interface
// Assumes: pins pass two flops; avalon-mm slave with waitrequest
// Notes: every output is a field of the registered state
`timescale 1ns/1ps
`include "spf_params.svh"
module spf_pin_function
  import spf_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic bit_clock_in,
  input wire logic line_lock_pulse,
  input wire logic line_signal_detect,
  input wire logic [17:0] rx_frame_data,
  output logic [17:0] tx_frame_data,
  output logic tx_frame_valid,
  input wire logic tx_serial_data_in,
  output logic rx_serial_data_out,
  output logic rx_serial_data_oe,
  input wire logic receive_frame_strobe_in,
  output logic receive_frame_strobe_out,
  output logic receive_frame_strobe_oe,
  output logic alt_pin_one_out,
  output logic alt_pin_one_oe,
  output logic alt_pin_two_out
);
  // =====================================================================
  // state and next state
  spf_state_t s_q; // registered state
  spf_state_t s_d; // next state
  spf_av_req_t req; // bundled bus request
  logic bk; // effective bit clock level
  logic bk_rise; // bit clock rising edge
  logic bk_fall; // bit clock falling edge
  logic start; // frame start at this rising edge
  logic d_slot; // current bit is a d channel bit
  logic tx_win; // transmit d window level
  logic [7:0] half; // recovered clock half period
  logic [7:0] flen; // bits per frame minus one in master mode
  logic tx_bit; // bit taken on falling edge
  logic acc; // bus access completes this edge

  assign req = '{address: avs_address, read: avs_read, write: avs_write, writedata: avs_writedata};

  // =====================================================================
  // next-state logic
  always_comb begin
    s_d = s_q;
    // two-flop synchronisers for outside inputs
    s_d.bclk_s1 = bit_clock_in;
    s_d.bclk_s2 = s_q.bclk_s1;
    s_d.fs_s1 = receive_frame_strobe_in;
    s_d.fs_s2 = s_q.fs_s1;
    s_d.txd_s1 = tx_serial_data_in;
    s_d.txd_s2 = s_q.txd_s1;
    s_d.lsd_s1 = line_signal_detect;
    s_d.lsd_s2 = s_q.lsd_s1;
    s_d.lock_s1 = line_lock_pulse;
    s_d.lock_s2 = s_q.lock_s1;
    s_d.lock_d = s_q.lock_s2;
    s_d.fs_d = s_q.fs_s2;
    // recovered clock divider, restarted by line lock edge
    half = s_q.fmt ? 8'(`SPF_HALF_F1) : 8'(`SPF_HALF_F0);
    flen = s_q.fmt ? 8'(`SPF_FRAME_F1 - 1) : 8'(`SPF_FRAME_F0 - 1);
    if (s_q.lock_s2 && !s_q.lock_d) begin
      s_d.div_cnt = 8'h00;
      s_d.rclk = 1'b1;
    end else if (s_q.div_cnt == half - 8'h01) begin
      s_d.div_cnt = 8'h00;
      s_d.rclk = ~s_q.rclk;
    end else begin
      s_d.div_cnt = s_q.div_cnt + 8'h01;
    end
    // master mode runs on the recovered clock, others on the pin
    bk = (s_q.mode == SPF_TEM) ? s_q.rclk : s_q.bclk_s2;
    s_d.bk_d = bk;
    bk_rise = bk && !s_q.bk_d;
    bk_fall = !bk && s_q.bk_d;
    start = 1'b0;
    if (bk_rise) begin
      if (s_q.mode == SPF_TEM) begin
        start = (s_q.fcnt == 8'h00);
        s_d.fcnt = (s_q.fcnt >= flen) ? 8'h00 : s_q.fcnt + 8'h01;
      end else begin
        start = s_q.pend;
        s_d.pend = 1'b0;
      end
    end
    // strobe rising edge arms the next frame in slave modes
    // placed after the clear so a coincident edge still arms
    if (s_q.mode != SPF_TEM && s_q.fs_s2 && !s_q.fs_d) begin
      s_d.pend = 1'b1;
    end
    // receive shifting on rising bit clock edges
    if (bk_rise) begin
      if (start) begin
        s_d.active = 1'b1;
        s_d.bit_cnt = 8'h00;
        s_d.rd_out = rx_frame_data[17];
        s_d.rx_sh = {rx_frame_data[16:0], 1'b0};
      end else if (s_q.active) begin
        if (s_q.bit_cnt == `SPF_LAST_BIT) begin
          s_d.active = 1'b0;
        end else begin
          s_d.bit_cnt = s_q.bit_cnt + 8'h01;
          s_d.rd_out = s_q.rx_sh[17];
          s_d.rx_sh = {s_q.rx_sh[16:0], 1'b0};
        end
      end
    end
    // data pin driven only while a frame shifts
    s_d.rd_oe = s_d.active;
    // transmit sampling on falling bit clock edges
    d_slot = s_q.active && (s_q.bit_cnt >= `SPF_D_FIRST);
    tx_bit = (s_q.d_clock_enable_command && d_slot) ? s_q.fs_s2 : s_q.txd_s2;
    s_d.tx_valid = 1'b0;
    if (bk_fall && s_q.active) begin
      s_d.tx_sh = {s_q.tx_sh[16:0], tx_bit};
      if (s_q.bit_cnt == `SPF_LAST_BIT) begin
        s_d.tx_data = {s_q.tx_sh[16:0], tx_bit};
        s_d.tx_valid = 1'b1;
      end
    end
    // frame strobe output in master mode
    d_slot = s_d.active && (s_d.bit_cnt >= `SPF_D_FIRST);
    tx_win = d_slot;
    s_d.fs_oe = (s_q.mode == SPF_TEM) && !s_q.d_clock_enable_command;
    if (s_q.fmt) begin
      s_d.fs_out = s_d.active && (s_d.bit_cnt >= `SPF_B2_FIRST) && (s_d.bit_cnt <= `SPF_B2_LAST);
    end else begin
      s_d.fs_out = s_d.active && (s_d.bit_cnt == 8'h00);
    end
    // alternate pin two
    s_d.p2_out = s_q.p2_sel ? s_q.rclk : tx_win;
    // alternate pin one
    case (s_q.p1_sel)
      SPF_P1_WAKE: begin
        s_d.p1_out = 1'b0;
        s_d.p1_oe = s_q.pdown && s_q.lsd_s2;
      end
      SPF_P1_RXWIN: begin
        s_d.p1_out = d_slot;
        s_d.p1_oe = 1'b1;
      end
      SPF_P1_RCLK: begin
        s_d.p1_out = s_q.rclk;
        s_d.p1_oe = 1'b1;
      end
      SPF_P1_TXWIN: begin
        s_d.p1_out = tx_win;
        s_d.p1_oe = 1'b1;
      end
      default: begin
        s_d.p1_out = 1'b0;
        s_d.p1_oe = 1'b0;
      end
    endcase
    // avalon slave: one wait cycle, action on the low edge
    // acc marks the edge at which the master sees waitrequest low
    acc = (req.read || req.write) && !s_q.wait_q;
    s_d.wait_q = !((req.read || req.write) && s_q.wait_q);
    if ((req.read || req.write) && s_q.wait_q && req.read) begin
      case (req.address)
        `SPF_CTRL_ADDR: s_d.rdata = {28'h0000000, s_q.pdown, s_q.fmt, s_q.mode};
        `SPF_STATUS_ADDR: s_d.rdata = {24'h000000, s_q.active, s_q.lsd_s2, s_q.d_clock_enable_command,
          s_q.p2_sel, s_q.p1_sel, s_q.mode};
        default: s_d.rdata = 32'h00000000;
      endcase
    end
    if (acc && req.write) begin
      case (req.address)
        `SPF_CTRL_ADDR: begin
          s_d.mode = spf_mode_t'(req.writedata[`SPF_CTRL_MODE_LSB +: 2]);
          s_d.fmt = req.writedata[`SPF_CTRL_FMT_BIT];
          s_d.pdown = req.writedata[`SPF_CTRL_PDOWN_BIT];
          // mode selection restores defaults
          s_d.p1_sel = SPF_P1_WAKE;
          s_d.p2_sel = (spf_mode_t'(req.writedata[1:0]) == SPF_TES);
          s_d.d_clock_enable_command = 1'b0;
        end
        `SPF_CMD_ADDR: begin
          if (req.writedata[7:3] == `SPF_PIN_DEFINE_COMMAND_TOP) begin
            s_d.p2_sel = req.writedata[2];
            s_d.p1_sel = spf_p1_t'(req.writedata[1:0]);
          end else if (req.writedata[7:0] == `SPF_D_CLOCK_ENABLE_COMMAND_CODE) begin
            s_d.d_clock_enable_command = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // =====================================================================
  // state register
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      // constants only: bus busy, pins released
      s_q <= '0;
      s_q.mode <= SPF_NTA;
      s_q.fmt <= `SPF_RST_FMT;
      s_q.pdown <= `SPF_RST_PDOWN;
      s_q.p1_sel <= SPF_P1_WAKE;
      s_q.wait_q <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from the state register
  assign avs_readdata = s_q.rdata;
  assign avs_waitrequest = s_q.wait_q;
  assign tx_frame_data = s_q.tx_data;
  assign tx_frame_valid = s_q.tx_valid;
  assign rx_serial_data_out = s_q.rd_out;
  assign rx_serial_data_oe = s_q.rd_oe;
  assign receive_frame_strobe_out = s_q.fs_out;
  assign receive_frame_strobe_oe = s_q.fs_oe;
  assign alt_pin_one_out = s_q.p1_out;
  assign alt_pin_one_oe = s_q.p1_oe;
  assign alt_pin_two_out = s_q.p2_out;

  // =====================================================================
  // checks
  sequence pin_define_command_wr_s;
    avs_write && !avs_waitrequest && avs_address == `SPF_CMD_ADDR && avs_writedata[7:3] == `SPF_PIN_DEFINE_COMMAND_TOP;
  endsequence
  sequence mode_wr_s;
    avs_write && !avs_waitrequest && avs_address == `SPF_CTRL_ADDR;
  endsequence
  pin_define_command_apply_a: assert property (@(posedge clk) disable iff (sys_rst)
    pin_define_command_wr_s |=> s_q.p2_sel == $past(avs_writedata[2]) && s_q.p1_sel == spf_p1_t'($past(avs_writedata[1:0])))
    else $error("pin define not applied");
  mode_default_a: assert property (@(posedge clk) disable iff (sys_rst)
    mode_wr_s |=> s_q.p1_sel == SPF_P1_WAKE && s_q.p2_sel == (s_q.mode == SPF_TES) && !s_q.d_clock_enable_command)
    else $error("mode did not restore defaults");
  d_clock_enable_command_strobe_a: assert property (@(posedge clk) disable iff (sys_rst)
    s_q.d_clock_enable_command |=> !receive_frame_strobe_oe)
    else $error("strobe pin still driven after d clock enable");
  rx_release_a: assert property (@(posedge clk) disable iff (sys_rst)
    !s_q.active |-> !rx_serial_data_oe)
    else $error("rx data driven outside frame");
  b2_strobe_a: assert property (@(posedge clk) disable iff (sys_rst)
    s_q.mode == SPF_TEM && s_q.fmt && s_q.active && s_q.bit_cnt == `SPF_B2_FIRST && !s_q.d_clock_enable_command
    ##1 s_q.bit_cnt == `SPF_B2_FIRST |-> receive_frame_strobe_out)
    else $error("strobe low in b2 slot");
  wake_pin_a: assert property (@(posedge clk) disable iff (sys_rst)
    s_q.p1_sel == SPF_P1_WAKE && !s_q.pdown |=> !alt_pin_one_oe)
    else $error("wake pin pulled while powered up");
  // pin outputs lag the select by one register stage
  wake_low_a: assert property (@(posedge clk) disable iff (sys_rst)
    alt_pin_one_oe && $past(s_q.p1_sel) == SPF_P1_WAKE |-> !alt_pin_one_out)
    else $error("wake pin driven high");
  slave_start_a: assert property (@(posedge clk) disable iff (sys_rst)
    s_q.mode != SPF_TEM && !s_q.active && !s_q.pend && s_q.fs_s2 && !s_q.fs_d |=> s_q.pend)
    else $error("strobe edge not armed");
  rxwin_pin_a: assert property (@(posedge clk) disable iff (sys_rst)
    s_q.p1_sel == SPF_P1_RXWIN && !s_q.active ##1 s_q.p1_sel == SPF_P1_RXWIN |-> !alt_pin_one_out)
    else $error("rx window high outside frame");
  bus_wait_a: assert property (@(posedge clk) disable iff (sys_rst)
    !avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low two cycles");
  // pins follow the active frame in the same cycle, the select one register stage later
  sequence rx_d_bit_s;
    s_q.p1_sel == SPF_P1_RXWIN && s_q.active && s_q.bit_cnt >= `SPF_D_FIRST;
  endsequence
  rxwin_high_a: assert property (@(posedge clk) disable iff (sys_rst)
    rx_d_bit_s ##1 rx_d_bit_s |-> alt_pin_one_out)
    else $error("rx window low during received d bits");
  rx_drive_a: assert property (@(posedge clk) disable iff (sys_rst)
    s_q.active |-> rx_serial_data_oe)
    else $error("rx data released inside frame");
  txwin_idle_a: assert property (@(posedge clk) disable iff (sys_rst)
    !s_q.p2_sel && !s_q.active |=> !alt_pin_two_out)
    else $error("tx window high outside frame");
  // strobe pin is only an output in terminal master mode
  fs_oe_mode_a: assert property (@(posedge clk) disable iff (sys_rst)
    s_q.mode != SPF_TEM |=> !receive_frame_strobe_oe)
    else $error("strobe pin driven outside master mode");
endmodule : spf_pin_function

/* sim/spf_far_side_model.sv */
// Purpose: far-side layer-2 controller model driving bit clock, strobe and tx data
// Assumes: bit clock period 125 ns, clock stands still between frames
// Notes: records rx data and window pins at each falling bit-clock edge
`timescale 1ns/1ps
module spf_far_side_model (
  input wire logic rx_serial_data_out,
  input wire logic rx_serial_data_oe,
  input wire logic alt_pin_one_out,
  input wire logic alt_pin_two_out,
  output logic bit_clock_in,
  output logic receive_frame_strobe_in,
  output logic tx_serial_data_in,
  output logic [17:0] rx_word,
  output logic [17:0] win1_word,
  output logic [17:0] win2_word,
  output logic oe_all
);
  // =====================================================================
  // idle levels at time zero
  initial begin
    bit_clock_in = 1'h0;
    receive_frame_strobe_in = 1'h0;
    tx_serial_data_in = 1'h0;
    oe_all = 1'h0;
  end
  // one frame: strobe rise, 18 bit times, one closing rise
  task send_frame(input logic [17:0] tx);
    integer i;
    oe_all = 1'h1;
    receive_frame_strobe_in = 1'h1;
    #62.5;
    for (i = 0; i < 18; i++) begin
      bit_clock_in = 1'h1;
      #10 tx_serial_data_in = tx[17 - i];
      #52.5 bit_clock_in = 1'h0;
      rx_word[17 - i] = rx_serial_data_out;
      win1_word[17 - i] = alt_pin_one_out;
      win2_word[17 - i] = alt_pin_two_out;
      oe_all = oe_all & rx_serial_data_oe;
      #62.5;
    end
    bit_clock_in = 1'h1;
    #62.5 bit_clock_in = 1'h0;
    receive_frame_strobe_in = 1'h0;
    // released data line shows the inverse, never a stale value
    tx_serial_data_in = ~tx_serial_data_in;
    #62.5;
  endtask : send_frame
endmodule : spf_far_side_model

/* sim/spf_pin_function_tb_top.sv */
// Purpose: self-checking bench for the pin-function block
// Assumes: far-side model in slave and nt modes, avalon master tasks
// Notes: random frame data from a fixed seed
`timescale 1ns/1ps
`include "spf_params.svh"
module spf_pin_function_tb_top;
  // =====================================================================
  // signals
  logic clk, sys_rst, avs_read, avs_write, avs_waitrequest, line_lock_pulse, line_signal_detect;
  logic [3:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [17:0] rx_frame_data, tx_frame_data, tx_seen, tx, rx_word, win1_word, win2_word;
  logic tx_frame_valid, txd, rxd, rxd_oe, fs_in, fs_out, fs_oe, p1, p1_oe, p2, bclk, oe_all, p;
  integer n_mismatch = 0, compares = 0, seed = 56018, i, n, w, r;
  spf_pin_function u_spf_pin_function (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .bit_clock_in(bclk),
    .line_lock_pulse(line_lock_pulse), .line_signal_detect(line_signal_detect),
    .rx_frame_data(rx_frame_data), .tx_frame_data(tx_frame_data), .tx_frame_valid(tx_frame_valid),
    .tx_serial_data_in(txd), .rx_serial_data_out(rxd), .rx_serial_data_oe(rxd_oe),
    .receive_frame_strobe_in(fs_in), .receive_frame_strobe_out(fs_out),
    .receive_frame_strobe_oe(fs_oe), .alt_pin_one_out(p1), .alt_pin_one_oe(p1_oe),
    .alt_pin_two_out(p2));
  spf_far_side_model u_spf_far_side_model (.rx_serial_data_out(rxd), .rx_serial_data_oe(rxd_oe),
    .alt_pin_one_out(p1), .alt_pin_two_out(p2), .bit_clock_in(bclk), .receive_frame_strobe_in(fs_in),
    .tx_serial_data_in(txd), .rx_word(rx_word), .win1_word(win1_word), .win2_word(win2_word),
    .oe_all(oe_all));
  // =====================================================================
  // clock and captured tx frame
  initial begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) if (tx_frame_valid === 1'h1) tx_seen <= tx_frame_data;
  // =====================================================================
  // verdict, compare and bus tasks
  task print_verdict;
    if (n_mismatch == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : print_verdict
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // holds the request until waitrequest is sampled low
  task av(input logic [3:0] a, input logic wr, input logic [31:0] d);
    integer k;
    avs_address <= a;
    avs_read <= !wr;
    avs_write <= wr;
    avs_writedata <= d;
    for (k = 0; k < 50; k++) begin
      @(posedge clk);
      if (avs_waitrequest === 1'h0) break;
    end
    if (k == 50) begin
      n_mismatch++;
      print_verdict;
    end
    q = avs_readdata;
    avs_read <= 1'h0;
    avs_write <= 1'h0;
    @(posedge clk);
  endtask : av
  // one slave frame with random payloads, then the rx word, data enable and tx word checks
  task frame_check;
    rx_frame_data <= 18'($random(seed));
    tx = 18'($random(seed));
    @(posedge clk);
    u_spf_far_side_model.send_frame(tx);
    repeat (10) @(posedge clk);
    chk("rx_word", 32'(rx_frame_data), 32'(rx_word));
    chk("rx_oe_frame", 32'h1, 32'(oe_all));
    chk("rx_oe_idle", 32'h0, 32'(rxd_oe));
    chk("tx_word", 32'(tx), 32'(tx_seen));
  endtask : frame_check
  // =====================================================================
  // main sequence
  initial begin
    sys_rst = 1'h1;
    avs_address = 4'h0;
    avs_read = 1'h0;
    avs_write = 1'h0;
    avs_writedata = 32'h0;
    line_lock_pulse = 1'h0;
    line_signal_detect = 1'h1;
    rx_frame_data = 18'h0;
    repeat (4) @(posedge clk);
    sys_rst <= 1'h0;
    repeat (5) @(posedge clk);
    chk("wake_oe", 32'h1, 32'(p1_oe));
    chk("wake_out", 32'h0, 32'(p1));
    av(`SPF_STATUS_ADDR, 1'h0, 32'h0);
    chk("status_rst", 32'h0, 32'(q[5:0]));
    av(4'hC, 1'h0, 32'h0);
    chk("unmapped", 32'h0, q);
    // slave mode, format one, powered up
    av(`SPF_CTRL_ADDR, 1'h1, 32'h7);
    line_lock_pulse <= 1'h1;
    repeat (5) @(posedge clk);
    line_lock_pulse <= 1'h0;
    chk("wake_up_oe", 32'h0, 32'(p1_oe));
    p = p2;
    for (n = 0; n < 200 && p2 === p; n++) @(posedge clk);
    p = p2;
    for (w = 0; w < 200 && p2 === p; w++) @(posedge clk);
    chk("rclk_half", 32'(`SPF_HALF_F1), 32'(w));
    r = $random(seed);
    for (i = 0; i < 8; i++) begin
      av(`SPF_CMD_ADDR, 1'h1, 32'hE0 | 32'((i + r) & 7));
      av(`SPF_STATUS_ADDR, 1'h0, 32'h0);
      chk("pin_sel", 32'((i + r) & 7), 32'(q[4:2]));
    end
    av(`SPF_CTRL_ADDR, 1'h1, 32'h7);
    av(`SPF_STATUS_ADDR, 1'h0, 32'h0);
    chk("sel_restored", 32'h4, 32'(q[5:2]));
    av(`SPF_CMD_ADDR, 1'h1, 32'hE1);
    for (i = 0; i < 3; i++) frame_check;
    chk("rx_window", 32'h3, 32'(win1_word));
    chk("tx_window", 32'h3, 32'(win2_word));
    // nt adaptive mode: pin two marks the d slot once per frame
    av(`SPF_CTRL_ADDR, 1'h1, 32'h0);
    frame_check;
    chk("nt_d_pulse", 32'h3, 32'(win2_word));
    // nt fixed mode: same d slot marking
    av(`SPF_CTRL_ADDR, 1'h1, 32'h1);
    frame_check;
    chk("ntf_d_pulse", 32'h3, 32'(win2_word));
    // terminal master, format one: strobe covers the b2 slot
    av(`SPF_CTRL_ADDR, 1'h1, 32'h6);
    av(`SPF_STATUS_ADDR, 1'h0, 32'h0);
    chk("tem_defaults", 32'h2, 32'(q[4:0]));
    for (n = 0; n < 30000 && fs_out !== 1'h1; n++) @(posedge clk);
    for (w = 0; w < 2000 && fs_out === 1'h1; w++) @(posedge clk);
    chk("fs_width", 32'(16 * `SPF_HALF_F1), 32'(w));
    chk("fs_oe_on", 32'h1, 32'(fs_oe));
    av(`SPF_CMD_ADDR, 1'h1, 32'hF1);
    repeat (5) @(posedge clk);
    chk("fs_oe_d_clock_enable_command", 32'h0, 32'(fs_oe));
    av(`SPF_STATUS_ADDR, 1'h0, 32'h0);
    chk("d_clock_enable_command_flag", 32'h1, 32'(q[5]));
    print_verdict;
  end
endmodule : spf_pin_function_tb_top
